//--- liuglb_regs.svh
// Register offsets, field positions, reset values and timing for the global control bank
`ifndef LIUGLB_REGS_SVH
`define LIUGLB_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LIUGLB_OFS_SOURCE_SEL     8'h82
`define LIUGLB_OFS_SLICER_LEVEL   8'h83
`define LIUGLB_OFS_CHANNEL_SEL    8'h8c
`define LIUGLB_OFS_COUNTER_CTRL   8'h8d
`define LIUGLB_OFS_COUNTER_DATA   8'h8e

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LIUGLB_RST_SOURCE_SEL     8'h00
`define LIUGLB_RST_SLICER_LEVEL   8'h00
`define LIUGLB_RST_CHANNEL_SEL    8'h00
`define LIUGLB_RST_COUNTER_CTRL   8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LIUGLB_BIT_TX_SOURCE      7
`define LIUGLB_BIT_TERM_SOURCE    6
`define LIUGLB_SLICER_MSB         3
`define LIUGLB_SLICER_LSB         2
`define LIUGLB_CHSEL_MSB          3
`define LIUGLB_CHSEL_LSB          0
`define LIUGLB_BIT_BYTE_CHOICE    2
`define LIUGLB_BIT_SINGLE_LATCH   1
`define LIUGLB_BIT_SINGLE_CLEAR   0

// ----------------------------------------------------------------
// Codes and thresholds
// ----------------------------------------------------------------
`define LIUGLB_SLICER_PCT_00      7'h3c
`define LIUGLB_SLICER_PCT_01      7'h41
`define LIUGLB_SLICER_PCT_10      7'h46
`define LIUGLB_SLICER_PCT_11      7'h37
`define LIUGLB_CHSEL_NONE         4'h0
`define LIUGLB_CHSEL_LAST         4'h8
`define LIUGLB_COUNT_MAX          16'hffff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LIUGLB_CLK_PERIOD_NS      50
`define LIUGLB_CLEAR_HOLD_NS      1000
`define LIUGLB_CLEAR_HOLD_CYC     ((`LIUGLB_CLEAR_HOLD_NS + `LIUGLB_CLK_PERIOD_NS - 1) / `LIUGLB_CLK_PERIOD_NS)

`endif

//--- liuglb_pkg.sv
// Shared types for the global control bank
package liuglb_pkg;
    typedef logic [7:0]  liuglb_byte_t;
    typedef logic [15:0] liuglb_count_t;
    typedef logic [7:0]  liuglb_chmask_t;
    typedef logic [6:0]  liuglb_pct_t;
endpackage : liuglb_pkg

//--- liuglb_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module liuglb_sync #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    always_comb begin
        next_meta     = async_in;
        next_sync_out = meta;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= next_meta;
            sync_out <= next_sync_out;
        end
    end
endmodule : liuglb_sync

//--- liuglb_lcv_counter.sv
// One channel's violation counter with its holding register
`timescale 1ns/1ps
`include "liuglb_regs.svh"
module liuglb_lcv_counter (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    // Events and commands
    input  wire logic                   violation_pulse,
    input  wire logic                   latch_req,
    input  wire logic                   clear_req,
    // Counts
    output liuglb_pkg::liuglb_count_t   running_count,
    output liuglb_pkg::liuglb_count_t   held_count
);
    liuglb_pkg::liuglb_count_t next_running;
    liuglb_pkg::liuglb_count_t next_held;

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    always_comb begin
        next_running = running_count;
        next_held    = held_count;
        // Saturate rather than wrap so a long error burst never reads small
        if (clear_req) begin
            next_running = '0;
        end else if (violation_pulse && (running_count != `LIUGLB_COUNT_MAX)) begin
            next_running = running_count + 16'h0001;
        end
        if (latch_req) begin
            next_held = running_count;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            running_count <= '0;
            held_count    <= '0;
        end else begin
            running_count <= next_running;
            held_count    <= next_held;
        end
    end
endmodule : liuglb_lcv_counter

//--- liuglb_control_regs.sv
// Global control register bank: source selects, slicer level, violation counter access
`timescale 1ns/1ps
`include "liuglb_regs.svh"
module liuglb_control_regs (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    // Host port
    input  wire logic                    host_cs,
    input  wire logic                    host_wr,
    input  wire logic                    host_rd,
    input  wire logic [7:0]              host_addr,
    input  wire logic [7:0]              host_wdata,
    output liuglb_pkg::liuglb_byte_t     host_rdata,
    output logic                         host_rvalid,
    // Per-channel register bits, same clock
    input  wire logic [7:0]              channel_tx_enable_bits,
    input  wire logic [7:0]              channel_termination_bits,
    // Hardware pins
    input  wire logic [7:0]              tx_enable_pins,
    input  wire logic                    receive_termination_pin,
    // Violation pulses from the channel decoders, same clock
    input  wire logic [7:0]              line_code_violation,
    // Steered functions
    output liuglb_pkg::liuglb_chmask_t   transmit_enable,
    output liuglb_pkg::liuglb_chmask_t   termination_select,
    output liuglb_pkg::liuglb_pct_t      slicer_threshold_pct,
    output wire logic                    transmit_enable_source,
    output wire logic                    termination_source
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Unlisted codes fall to an empty mask
    function automatic liuglb_pkg::liuglb_chmask_t chsel_mask(input logic [3:0] code);
        liuglb_pkg::liuglb_chmask_t m;
        m = '0;
        if ((code != `LIUGLB_CHSEL_NONE) && (code <= `LIUGLB_CHSEL_LAST)) begin
            m = liuglb_pkg::liuglb_chmask_t'(8'h01 << (code - 4'h1));
        end
        return m;
    endfunction : chsel_mask

    function automatic liuglb_pkg::liuglb_pct_t slicer_pct(input logic [1:0] level);
        liuglb_pkg::liuglb_pct_t p;
        p = `LIUGLB_SLICER_PCT_00;
        case (level)
            2'h0: begin
                p = `LIUGLB_SLICER_PCT_00;
            end
            2'h1: begin
                p = `LIUGLB_SLICER_PCT_01;
            end
            2'h2: begin
                p = `LIUGLB_SLICER_PCT_10;
            end
            2'h3: begin
                p = `LIUGLB_SLICER_PCT_11;
            end
            default: begin
                p = `LIUGLB_SLICER_PCT_00;
            end
        endcase
        return p;
    endfunction : slicer_pct

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    liuglb_pkg::liuglb_byte_t   control_source_select;
    liuglb_pkg::liuglb_byte_t   receive_slicer_level;
    liuglb_pkg::liuglb_byte_t   violation_counter_channel_select;
    liuglb_pkg::liuglb_byte_t   counter_control;
    logic                       latch_prev;
    liuglb_pkg::liuglb_byte_t   next_control_source_select;
    liuglb_pkg::liuglb_byte_t   next_receive_slicer_level;
    liuglb_pkg::liuglb_byte_t   next_violation_counter_channel_select;
    liuglb_pkg::liuglb_byte_t   next_counter_control;
    logic                       next_latch_prev;
    liuglb_pkg::liuglb_byte_t   next_host_rdata;
    logic                       next_host_rvalid;
    liuglb_pkg::liuglb_chmask_t next_transmit_enable;
    liuglb_pkg::liuglb_chmask_t next_termination_select;
    liuglb_pkg::liuglb_pct_t    next_slicer_threshold_pct;
    logic [8:0]                 pins_sync;
    liuglb_pkg::liuglb_chmask_t selected_mask;
    liuglb_pkg::liuglb_chmask_t latch_reqs;
    liuglb_pkg::liuglb_chmask_t clear_reqs;
    logic                       single_channel_latch;
    logic                       single_channel_clear;
    logic                       count_byte_choice;
    logic                       write_hit;
    logic                       read_hit;
    liuglb_pkg::liuglb_count_t  held_counts   [8];
    liuglb_pkg::liuglb_count_t  running_counts[8];

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    liuglb_sync #(
        .WIDTH (9)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in ({receive_termination_pin, tx_enable_pins}),
        .sync_out (pins_sync)
    );

    // ----------------------------------------------------------------
    // Field views
    // ----------------------------------------------------------------
    assign transmit_enable_source = control_source_select[`LIUGLB_BIT_TX_SOURCE];
    assign termination_source     = control_source_select[`LIUGLB_BIT_TERM_SOURCE];
    assign single_channel_latch   = counter_control[`LIUGLB_BIT_SINGLE_LATCH];
    assign single_channel_clear   = counter_control[`LIUGLB_BIT_SINGLE_CLEAR];
    assign count_byte_choice      = counter_control[`LIUGLB_BIT_BYTE_CHOICE];
    assign write_hit              = host_cs && host_wr;
    assign read_hit               = host_cs && host_rd;
    assign selected_mask          = chsel_mask(
        violation_counter_channel_select[`LIUGLB_CHSEL_MSB:`LIUGLB_CHSEL_LSB]);

    // Latch on the rising edge of the bit so a bit left at one latches only once and the held count stays frozen
    assign latch_reqs = (single_channel_latch && !latch_prev) ? selected_mask : '0;
    assign clear_reqs = single_channel_clear ? selected_mask : '0;

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_counter
            liuglb_lcv_counter u_counter (
                .sys_clk         (sys_clk),
                .resetn          (resetn),
                .violation_pulse (line_code_violation[gi]),
                .latch_req       (latch_reqs[gi]),
                .clear_req       (clear_reqs[gi]),
                .running_count   (running_counts[gi]),
                .held_count      (held_counts[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_comb begin
        next_control_source_select            = control_source_select;
        next_receive_slicer_level             = receive_slicer_level;
        next_violation_counter_channel_select = violation_counter_channel_select;
        next_counter_control                  = counter_control;
        next_latch_prev                       = single_channel_latch;
        // Whole bytes stored, spare bits included
        if (write_hit) begin
            case (host_addr)
                `LIUGLB_OFS_SOURCE_SEL: begin
                    next_control_source_select = host_wdata;
                end
                `LIUGLB_OFS_SLICER_LEVEL: begin
                    next_receive_slicer_level = host_wdata;
                end
                `LIUGLB_OFS_CHANNEL_SEL: begin
                    next_violation_counter_channel_select = host_wdata;
                end
                `LIUGLB_OFS_COUNTER_CTRL: begin
                    next_counter_control = host_wdata;
                end
                default: begin
                    next_counter_control = counter_control;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    always_comb begin
        liuglb_pkg::liuglb_count_t held;
        held             = '0;
        next_host_rdata  = '0;
        next_host_rvalid = read_hit;
        for (int i = 0; i < 8; i++) begin
            if (selected_mask[i]) begin
                held = held_counts[i];
            end
        end
        if (read_hit) begin
            case (host_addr)
                `LIUGLB_OFS_SOURCE_SEL: begin
                    next_host_rdata = control_source_select;
                end
                `LIUGLB_OFS_SLICER_LEVEL: begin
                    next_host_rdata = receive_slicer_level;
                end
                `LIUGLB_OFS_CHANNEL_SEL: begin
                    next_host_rdata = violation_counter_channel_select;
                end
                `LIUGLB_OFS_COUNTER_CTRL: begin
                    next_host_rdata = counter_control;
                end
                `LIUGLB_OFS_COUNTER_DATA: begin
                    // No channel selected leaves held at zero
                    next_host_rdata = count_byte_choice ? held[15:8] : held[7:0];
                end
                default: begin
                    next_host_rdata = '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Steered functions
    // ----------------------------------------------------------------
    always_comb begin
        // Per-channel bits still stored upstream, only the mux ignores them
        next_transmit_enable = transmit_enable_source ? pins_sync[7:0]
                                                      : channel_tx_enable_bits;
        next_termination_select = termination_source ? {8{pins_sync[8]}}
                                                     : channel_termination_bits;
        next_slicer_threshold_pct = slicer_pct(
            receive_slicer_level[`LIUGLB_SLICER_MSB:`LIUGLB_SLICER_LSB]);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            control_source_select            <= `LIUGLB_RST_SOURCE_SEL;
            receive_slicer_level             <= `LIUGLB_RST_SLICER_LEVEL;
            violation_counter_channel_select <= `LIUGLB_RST_CHANNEL_SEL;
            counter_control                  <= `LIUGLB_RST_COUNTER_CTRL;
            latch_prev                       <= 1'b0;
            host_rdata                       <= '0;
            host_rvalid                      <= 1'b0;
            transmit_enable                  <= '0;
            termination_select               <= '0;
            slicer_threshold_pct             <= `LIUGLB_SLICER_PCT_00;
        end else begin
            control_source_select            <= next_control_source_select;
            receive_slicer_level             <= next_receive_slicer_level;
            violation_counter_channel_select <= next_violation_counter_channel_select;
            counter_control                  <= next_counter_control;
            latch_prev                       <= next_latch_prev;
            host_rdata                       <= next_host_rdata;
            host_rvalid                      <= next_host_rvalid;
            transmit_enable                  <= next_transmit_enable;
            termination_select               <= next_termination_select;
            slicer_threshold_pct             <= next_slicer_threshold_pct;
        end
    end
endmodule : liuglb_control_regs

//--- liuglb_properties.sv
// Port checker for the global control bank
`timescale 1ns/1ps
`include "liuglb_regs.svh"
module liuglb_properties (
    // Clock and reset
    input logic                       sys_clk,
    input logic                       resetn,
    // Host port
    input logic                       host_cs,
    input logic                       host_wr,
    input logic                       host_rd,
    input logic [7:0]                 host_addr,
    input logic [7:0]                 host_wdata,
    input liuglb_pkg::liuglb_byte_t   host_rdata,
    input logic                       host_rvalid,
    // Channel side
    input logic [7:0]                 channel_tx_enable_bits,
    input logic [7:0]                 channel_termination_bits,
    input logic [7:0]                 tx_enable_pins,
    input logic                       receive_termination_pin,
    input logic [7:0]                 line_code_violation,
    // Steered functions
    input liuglb_pkg::liuglb_chmask_t transmit_enable,
    input liuglb_pkg::liuglb_chmask_t termination_select,
    input liuglb_pkg::liuglb_pct_t    slicer_threshold_pct,
    input logic                       transmit_enable_source,
    input logic                       termination_source
);
    // ------------------------------
    // Checks
    // ------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [3:0] sel_q;
    logic       wr_src;
    assign wr_src = host_cs && host_wr && host_addr == `LIUGLB_OFS_SOURCE_SEL;
    // Counter select mirror
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= 4'h0;
        end else if (host_cs && host_wr && host_addr == `LIUGLB_OFS_CHANNEL_SEL) begin
            sel_q <= host_wdata[3:0];
        end
    end
    sequence s_slicer_write;
        host_cs && host_wr && host_addr == `LIUGLB_OFS_SLICER_LEVEL ##1 1'b1;
    endsequence
    property p_tx_source;
        wr_src |=> transmit_enable_source == $past(host_wdata[7]);
    endproperty
    property p_term_source;
        wr_src |=> termination_source == $past(host_wdata[6]);
    endproperty
    property p_reset_sources;
        $rose(resetn) |-> !transmit_enable_source && !termination_source;
    endproperty
    property p_slicer;
        s_slicer_write |-> ##1 slicer_threshold_pct ==
            ($past(host_wdata[3:2], 2) == 2'h0 ? `LIUGLB_SLICER_PCT_00 :
             $past(host_wdata[3:2], 2) == 2'h1 ? `LIUGLB_SLICER_PCT_01 :
             $past(host_wdata[3:2], 2) == 2'h2 ? `LIUGLB_SLICER_PCT_10 : `LIUGLB_SLICER_PCT_11);
    endproperty
    property p_tx_follow;
        !transmit_enable_source |=> transmit_enable == $past(channel_tx_enable_bits);
    endproperty
    property p_term_follow;
        !termination_source |=> termination_select == $past(channel_termination_bits);
    endproperty
    property p_read_answer;
        $past(resetn) |-> host_rvalid == $past(host_cs && host_rd)
            && (host_rvalid || host_rdata == 8'h00);
    endproperty
    property p_none_read;
        host_cs && host_rd && host_addr == `LIUGLB_OFS_COUNTER_DATA && (sel_q == 4'h0 || sel_q > 4'h8)
            |=> host_rdata == 8'h00;
    endproperty
    a_tx_source: assert property (p_tx_source) else $error("tx source bit wrong");
    a_term_source: assert property (p_term_source) else $error("term source bit wrong");
    a_reset_sources: assert property (p_reset_sources) else $error("sources not zero");
    a_slicer: assert property (p_slicer) else $error("slicer decode wrong");
    a_tx_follow: assert property (p_tx_follow) else $error("tx enable not from bits");
    a_term_follow: assert property (p_term_follow) else $error("term not from bits");
    a_read_answer: assert property (p_read_answer) else $error("read answer wrong");
    a_none_read: assert property (p_none_read) else $error("no channel read nonzero");
endmodule : liuglb_properties

bind liuglb_control_regs liuglb_properties u_props (.*);

//--- liuglb_host_model.sv
// Host microprocessor model for the register port
`timescale 1ns/1ps
`include "liuglb_regs.svh"
module liuglb_host_model (
    // Clock
    input  wire logic       sys_clk,
    // Host port
    output logic            host_cs,
    output logic            host_wr,
    output logic            host_rd,
    output logic [7:0]      host_addr,
    output logic [7:0]      host_wdata,
    input  wire logic [7:0] host_rdata,
    input  wire logic       host_rvalid
);
    // ------------------------------
    // Bus cycles
    // ------------------------------
    initial begin
        {host_cs, host_wr, host_rd, host_addr, host_wdata} = '0;
    end
    // Released lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        host_cs <= 1'b1;
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge sys_clk);
        host_cs <= 1'b0;
        host_wr <= 1'b0;
        host_addr <= ~a;
        host_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        host_cs <= 1'b1;
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge sys_clk);
        host_cs <= 1'b0;
        host_rd <= 1'b0;
        host_addr <= ~a;
        @(posedge sys_clk);
        d = (host_rvalid === 1'b1) ? host_rdata : 8'hxx;
    endtask : rd
    task automatic clear_selected();
        wr(`LIUGLB_OFS_COUNTER_CTRL, 8'h01);
        repeat (`LIUGLB_CLEAR_HOLD_CYC) @(posedge sys_clk);
        wr(`LIUGLB_OFS_COUNTER_CTRL, 8'h00);
    endtask : clear_selected
endmodule : liuglb_host_model

//--- liuglb_control_regs_tb.sv
// Self-checking bench for the global control bank
`timescale 1ns/1ps
`include "liuglb_regs.svh"
module liuglb_control_regs_tb;
    logic                       sys_clk, resetn, term_pin;
    logic [7:0]                 ch_tx, ch_term, pins, lcv;
    logic                       cs, wr, rd, rvalid, tx_src, term_src;
    logic [7:0]                 addr, wdata;
    liuglb_pkg::liuglb_byte_t   rdata;
    liuglb_pkg::liuglb_chmask_t tx_en, term_sel;
    liuglb_pkg::liuglb_pct_t    pct;
    int                         fails, n_tests, cycles;
    liuglb_host_model u_host (.sys_clk, .host_cs(cs), .host_wr(wr), .host_rd(rd),
        .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata), .host_rvalid(rvalid));
    liuglb_control_regs u_dut (.sys_clk, .resetn, .host_cs(cs),
        .host_wr(wr), .host_rd(rd), .host_addr(addr), .host_wdata(wdata),
        .host_rdata(rdata), .host_rvalid(rvalid), .channel_tx_enable_bits(ch_tx),
        .channel_termination_bits(ch_term), .tx_enable_pins(pins),
        .receive_termination_pin(term_pin), .line_code_violation(lcv),
        .transmit_enable(tx_en), .termination_select(term_sel), .slicer_threshold_pct(pct),
        .transmit_enable_source(tx_src), .termination_source(term_src));
    // ------------------------------
    // Helpers and scenarios
    // ------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            summarize();
        end
    end
    task automatic summarize();
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t out got %h exp %h", $time, got, exp);
        end
    endtask : chk_out
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk_reg(d, exp);
    endtask : rd_chk
    task automatic sel_latch(input logic [7:0] c);
        u_host.wr(`LIUGLB_OFS_CHANNEL_SEL, c);
        u_host.wr(`LIUGLB_OFS_COUNTER_CTRL, 8'h00);
        u_host.wr(`LIUGLB_OFS_COUNTER_CTRL, 8'h02);
    endtask : sel_latch
    task automatic pulse(input logic [7:0] m, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            lcv <= m;
            @(posedge sys_clk);
            lcv <= 8'h00;
        end
    endtask : pulse
    task automatic t_reset();
        chk_out({6'h00, tx_src, term_src}, 8'h00);
        chk_out({1'b0, pct}, {1'b0, `LIUGLB_SLICER_PCT_00});
        rd_chk(`LIUGLB_OFS_SOURCE_SEL, 8'h00);
        rd_chk(`LIUGLB_OFS_SLICER_LEVEL, 8'h00);
        rd_chk(`LIUGLB_OFS_CHANNEL_SEL, 8'h00);
        rd_chk(`LIUGLB_OFS_COUNTER_DATA, 8'h00);
    endtask : t_reset
    task automatic t_loose();
        u_host.wr(`LIUGLB_OFS_SOURCE_SEL, 8'h3f);
        u_host.wr(`LIUGLB_OFS_SLICER_LEVEL, 8'hf3);
        u_host.wr(`LIUGLB_OFS_CHANNEL_SEL, 8'hf0);
        u_host.wr(8'h84, 8'hff);
        rd_chk(`LIUGLB_OFS_SOURCE_SEL, 8'h3f);
        rd_chk(`LIUGLB_OFS_SLICER_LEVEL, 8'hf3);
        rd_chk(`LIUGLB_OFS_CHANNEL_SEL, 8'hf0);
        rd_chk(8'h84, 8'h00);
        rd_chk(`LIUGLB_OFS_COUNTER_DATA, 8'h00);
        chk_out({6'h00, tx_src, term_src}, 8'h00);
        chk_out({1'b0, pct}, {1'b0, `LIUGLB_SLICER_PCT_00});
    endtask : t_loose
    task automatic t_slicer();
        liuglb_pkg::liuglb_pct_t tbl [4];
        tbl = '{`LIUGLB_SLICER_PCT_00, `LIUGLB_SLICER_PCT_01, `LIUGLB_SLICER_PCT_10,
                `LIUGLB_SLICER_PCT_11};
        for (int i = 0; i < 4; i++) begin
            u_host.wr(`LIUGLB_OFS_SLICER_LEVEL, 8'(i << 2));
            repeat (2) @(posedge sys_clk);
            chk_out({1'b0, pct}, {1'b0, tbl[i]});
        end
    endtask : t_slicer
    task automatic t_source();
        @(posedge sys_clk);
        ch_tx <= 8'ha5;
        ch_term <= 8'h3c;
        pins <= 8'h5a;
        term_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk_out(tx_en, 8'ha5);
        chk_out(term_sel, 8'h3c);
        u_host.wr(`LIUGLB_OFS_SOURCE_SEL, 8'h80);
        repeat (4) @(posedge sys_clk);
        chk_out(tx_en, 8'h5a);
        chk_out(term_sel, 8'h3c);
        u_host.wr(`LIUGLB_OFS_SOURCE_SEL, 8'hc0);
        ch_tx <= 8'h00;
        ch_term <= 8'h00;
        repeat (4) @(posedge sys_clk);
        chk_out(tx_en, 8'h5a);
        chk_out(term_sel, 8'hff);
        rd_chk(`LIUGLB_OFS_SOURCE_SEL, 8'hc0);
        u_host.wr(`LIUGLB_OFS_SOURCE_SEL, 8'h00);
        repeat (4) @(posedge sys_clk);
        chk_out(tx_en, 8'h00);
    endtask : t_source
    task automatic t_counter();
        pulse(8'h25, 5);
        pulse(8'h20, 295);
        pulse(8'h80, 1);
        sel_latch(8'h03);
        rd_chk(`LIUGLB_OFS_COUNTER_DATA, 8'h05);
        sel_latch(8'h06);
        rd_chk(`LIUGLB_OFS_COUNTER_DATA, 8'h2c);
        u_host.wr(`LIUGLB_OFS_COUNTER_CTRL, 8'h04);
        rd_chk(`LIUGLB_OFS_COUNTER_DATA, 8'h01);
        sel_latch(8'h08);
        rd_chk(`LIUGLB_OFS_COUNTER_DATA, 8'h01);
        sel_latch(8'h09);
        rd_chk(`LIUGLB_OFS_COUNTER_DATA, 8'h00);
        u_host.wr(`LIUGLB_OFS_CHANNEL_SEL, 8'h00);
        rd_chk(`LIUGLB_OFS_COUNTER_DATA, 8'h00);
        u_host.wr(`LIUGLB_OFS_CHANNEL_SEL, 8'h03);
        u_host.clear_selected();
        sel_latch(8'h03);
        rd_chk(`LIUGLB_OFS_COUNTER_DATA, 8'h00);
        sel_latch(8'h06);
        rd_chk(`LIUGLB_OFS_COUNTER_DATA, 8'h2c);
    endtask : t_counter
    initial begin
        resetn = 1'b0;
        {term_pin, ch_tx, ch_term, pins, lcv} = '0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_loose();
        t_slicer();
        t_source();
        t_counter();
        summarize();
    end
endmodule : liuglb_control_regs_tb
